// >>> lcb_pkg.sv
/*
 File: shared constants for the LCD driver serial receiver and blinker.
 Assumes: included by every design file of the block through import.
*/
package lcb_pkg;
   localparam logic [5:0] ADDR_PREFIX = 6'h1C;
   localparam int ADDR_PREFIX_MSB = 7;
   localparam int ADDR_SEL_BIT = 1;
   localparam int ADDR_RW_BIT = 0;
   localparam int CONT_BIT = 7;
   localparam int BLINK_DIV1 = 768;
   localparam int BLINK_DIV2 = 1536;
   localparam int BLINK_DIV3 = 3072;
   localparam logic [1:0] RATE_OFF = 2'h0;
   localparam logic [1:0] RATE_1 = 2'h1;
   localparam logic [1:0] RATE_2 = 2'h2;
   localparam logic [1:0] RATE_3 = 2'h3;
   localparam logic [3:0] BLINK_OPC = 4'hE;
   localparam logic [1:0] MODE_OPC = 2'h2;
   localparam logic [3:0] DEVSEL_OPC = 4'hC;
   localparam logic [4:0] BANK_OPC = 5'h1E;
   localparam int MODE_EN_BIT = 3;
   localparam int MODE_BIAS_BIT = 2;
   localparam int BLINK_ALT_BIT = 2;
   localparam logic [1:0] DRIVE_STATIC = 2'h1;
   localparam logic [1:0] DRIVE_MUX2 = 2'h2;
   localparam logic [1:0] DRIVE_MUX3 = 2'h3;
   localparam logic [1:0] DRIVE_MUX4 = 2'h0;
   localparam logic [5:0] RAM_LAST = 6'h27;
   localparam logic [5:0] PTR_RST = 6'h00;
   localparam logic [2:0] SUBADDR_RST = 3'h0;
   localparam logic [1:0] DRIVE_RST = 2'h0;
   localparam logic [1:0] RATE_RST = 2'h0;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 17;
endpackage

// >>> lcb_fifo.sv
/*
 File: synchronous FIFO with valid/ready on both sides.
 Assumes: one clock, asynchronous active-low reset; depth a power of two.
*/
`timescale 1ns/10ps
module lcb_fifo
   import lcb_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
   logic push, pop;

   assign in_ready_out = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_reg != rd_reg;
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_reg[AW-1:0]];

   always_comb begin
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage has no reset; entries are only read once written
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data_in;
      end
   end

   a_fifo_no_overflow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_reg - rd_reg) <= (AW+1)'(DEPTH))
      else $error("fifo holds more entries than its depth");
endmodule

// >>> lcb_receiver.sv
/*
 File: two-wire serial slave receiver, command decoder and blinker of a segment LCD driver.
 Assumes: the serial lines are oversampled by a system clock far faster than the bit rate;
 display writes leave through a FIFO towards a display RAM outside this block.
*/
// Summary of operation
// - Blink rates divide the clock by 768, 1536, 3072; off means no blink.
// - Static and 1:2 modes with alternate blink swap displayed bank each half period.
// - Data falling while clock high is start; device begins address reception.
// - Data rising while clock high is stop; device ends current transfer.
// - Each byte is followed by an acknowledge cycle; byte count unbounded.
// - Acknowledge holds data low through the whole high phase of that pulse.
// - Device is slave receiver only; its sole drive is the acknowledge.
// - Address upper six bits 011100, bit 1 equals select pin, bit 0 read/write.
// - Read requests are not answered; master always sends write.
// - Matching devices acknowledge address; others ignore until next start.
// - Bytes are commands while top bit is 1; after top bit 0 comes data.
// - Every selected device acknowledges each command byte.
// - Data bytes stored at pointer; pointer then advances, subaddress only when pointer wraps past 39.
// - Data bytes acknowledged only when subaddress counter equals hardware pins.
// - Repeated start returns the device to expecting an address byte.
// - Blink mode and rate come from the latest blink-select command.
// - Blink command: bits 6..3 are 1110, bit 2 alternate, bits 1..0 rate.
// - Display bytes are stored as soon as received, before the acknowledge.
// - Mode-set bit 3 blanks the display when 0 and enables it when 1.
// - Bank choice shows row 2 for 0 in static, rows 2,3 for 0,1 in 1:2.
`timescale 1ns/10ps
module lcb_receiver
   import lcb_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Straps
   input wire logic addr_select_pin,
   input wire logic hw_subaddr_pin0,
   input wire logic hw_subaddr_pin1,
   input wire logic hw_subaddr_pin2,
   // Display write stream: {bank, two unused pad bits, pointer, data}
   output logic wr_valid_out,
   input wire logic wr_ready_in,
   output logic [5:0] wr_ptr_out,
   output logic [7:0] wr_data_out,
   output logic wr_bank_out,
   // Display configuration and blink state
   output logic [1:0] drive_mode_out,
   output logic bias_half_out,
   output logic disp_enable_out,
   output logic out_bank_out,
   output logic [1:0] blink_rate_field,
   output logic blink_alt_out,
   output logic disp_blank_out,
   output logic disp_bank_out,
   output logic fifo_stall_out
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_CMD = 4'h4,
      ST_DATA = 4'h8
   } lcb_state_t;

   // Pointer increment per received data byte, stored or not, for the given drive mode
   function automatic logic [5:0] ptr_step(input logic [1:0] mode);
      unique case (mode)
         DRIVE_STATIC: ptr_step = 6'h08;
         DRIVE_MUX2: ptr_step = 6'h04;
         DRIVE_MUX3: ptr_step = 6'h03;
         default: ptr_step = 6'h02;
      endcase
   endfunction

   // Synchronisers: first stage read only by the second
   logic scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic scl_rise, scl_fall, start_det, stop_det;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg <= sda_s2_reg;
      end
   end

   assign scl_rise = scl_s2_reg && !scl_d_reg;
   assign scl_fall = !scl_s2_reg && scl_d_reg;
   assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
   assign stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

   // Straps are plain levels sampled like any pin
   logic [3:0] strap_s1_reg, strap_reg;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_s1_reg <= 4'h0;
         strap_reg <= 4'h0;
      end else begin
         strap_s1_reg <= {addr_select_pin, hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0};
         strap_reg <= strap_s1_reg;
      end
   end

   // Protocol state
   lcb_state_t st_reg, st_next;
   logic [7:0] sh_reg, sh_next;
   logic [3:0] bit_reg, bit_next;
   logic ack_reg, ack_next;
   logic in_ack_reg, in_ack_next;
   logic [5:0] ptr_reg, ptr_next;
   logic [2:0] sub_reg, sub_next;
   logic [1:0] mode_reg, mode_next;
   logic bias_reg, bias_next, en_reg, en_next;
   logic ibank_reg, ibank_next, obank_reg, obank_next;
   logic [1:0] rate_reg, rate_next;
   logic alt_reg, alt_next;
   logic push;
   logic [7:0] byte_now;
   logic sub_match;
   logic fifo_ready;
   logic [6:0] sum;

   assign byte_now = {sh_reg[6:0], sda_s2_reg};
   assign sub_match = sub_reg == strap_reg[2:0];

   always_comb begin
      st_next = st_reg;
      sh_next = sh_reg;
      bit_next = bit_reg;
      ack_next = ack_reg;
      in_ack_next = in_ack_reg;
      ptr_next = ptr_reg;
      sub_next = sub_reg;
      mode_next = mode_reg;
      bias_next = bias_reg;
      en_next = en_reg;
      ibank_next = ibank_reg;
      obank_next = obank_reg;
      rate_next = rate_reg;
      alt_next = alt_reg;
      push = 1'b0;
      sum = 7'h00;
      if (start_det) begin
         st_next = ST_ADDR;
         bit_next = 4'h0;
         ack_next = 1'b0;
         in_ack_next = 1'b0;
      end else if (stop_det) begin
         st_next = ST_IDLE;
         ack_next = 1'b0;
         in_ack_next = 1'b0;
      end else if (st_reg != ST_IDLE) begin
         if (scl_rise && !in_ack_reg) begin
            sh_next = byte_now;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
               // Byte complete at the eighth rising edge
               unique case (st_reg)
                  ST_ADDR: begin
                     if (byte_now[ADDR_PREFIX_MSB -: 6] == ADDR_PREFIX &&
                         byte_now[ADDR_SEL_BIT] == strap_reg[3] &&
                         !byte_now[ADDR_RW_BIT]) begin
                        ack_next = 1'b1;
                        st_next = ST_CMD;
                     end else begin
                        st_next = ST_IDLE;
                     end
                  end
                  ST_CMD: begin
                     ack_next = 1'b1;
                     if (byte_now[6:5] == MODE_OPC) begin
                        en_next = byte_now[MODE_EN_BIT];
                        bias_next = byte_now[MODE_BIAS_BIT];
                        mode_next = byte_now[1:0];
                     end else if (!byte_now[6]) begin
                        ptr_next = byte_now[5:0];
                     end else if (byte_now[6:3] == DEVSEL_OPC) begin
                        sub_next = byte_now[2:0];
                     end else if (byte_now[6:2] == BANK_OPC) begin
                        ibank_next = byte_now[1];
                        obank_next = byte_now[0];
                     end else if (byte_now[6:3] == BLINK_OPC) begin
                        alt_next = byte_now[BLINK_ALT_BIT];
                        rate_next = byte_now[1:0];
                     end
                     if (!byte_now[CONT_BIT]) begin
                        st_next = ST_DATA;
                     end
                  end
                  ST_DATA: begin
                     ack_next = sub_match;
                     push = sub_match;
                     sum = {1'b0, ptr_reg} + {1'b0, ptr_step(mode_reg)};
                     if (sum > {1'b0, RAM_LAST}) begin
                        ptr_next = 6'(sum - 7'h28);
                        sub_next = sub_reg + 3'h1;
                     end else begin
                        ptr_next = sum[5:0];
                     end
                  end
                  default: st_next = ST_IDLE;
               endcase
            end
         end else if (scl_fall && bit_reg == 4'h8 && !in_ack_reg) begin
            in_ack_next = 1'b1;
         end else if (scl_fall && in_ack_reg) begin
            in_ack_next = 1'b0;
            ack_next = 1'b0;
            bit_next = 4'h0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= ST_IDLE;
         sh_reg <= 8'h00;
         bit_reg <= 4'h0;
         ack_reg <= 1'b0;
         in_ack_reg <= 1'b0;
         ptr_reg <= PTR_RST;
         sub_reg <= SUBADDR_RST;
         mode_reg <= DRIVE_RST;
         bias_reg <= 1'b0;
         en_reg <= 1'b0;
         ibank_reg <= 1'b0;
         obank_reg <= 1'b0;
         rate_reg <= RATE_RST;
         alt_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         bit_reg <= bit_next;
         ack_reg <= ack_next;
         in_ack_reg <= in_ack_next;
         ptr_reg <= ptr_next;
         sub_reg <= sub_next;
         mode_reg <= mode_next;
         bias_reg <= bias_next;
         en_reg <= en_next;
         ibank_reg <= ibank_next;
         obank_reg <= obank_next;
         rate_reg <= rate_next;
         alt_reg <= alt_next;
      end
   end

   // Only ever pulls low, and only in the acknowledge slot
   assign sda_out = 1'b0;
   assign sda_oe_out = ack_reg && in_ack_reg;

   // A full FIFO drops the byte although it was acknowledged; the stall flag warns the consumer
   logic unused_ready, unused_pad;
   assign fifo_stall_out = !fifo_ready;
   lcb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in({ibank_reg && (mode_reg == DRIVE_STATIC || mode_reg == DRIVE_MUX2),
                   2'b00, ptr_reg, byte_now}),
      .out_valid_out(wr_valid_out),
      .out_ready_in(wr_ready_in),
      .out_data_out({wr_bank_out, unused_ready, unused_pad, wr_ptr_out, wr_data_out})
   );

   // Blinker: free-running counter, half period selects phase
   logic [11:0] blk_reg, blk_next;
   logic [11:0] half;
   logic phase_reg, phase_next;
   always_comb begin
      unique case (rate_reg)
         RATE_1: half = 12'(BLINK_DIV1 / 2);
         RATE_2: half = 12'(BLINK_DIV2 / 2);
         RATE_3: half = 12'(BLINK_DIV3 / 2);
         default: half = 12'(BLINK_DIV1 / 2);
      endcase
      blk_next = blk_reg + 12'h001;
      phase_next = phase_reg;
      if (blk_reg >= half - 12'h001) begin
         blk_next = 12'h000;
         phase_next = !phase_reg;
      end
      if (rate_reg == RATE_OFF) begin
         phase_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         blk_reg <= 12'h000;
         phase_reg <= 1'b0;
      end else begin
         blk_reg <= blk_next;
         phase_reg <= phase_next;
      end
   end

   logic bank_capable;
   assign bank_capable = mode_reg == DRIVE_STATIC || mode_reg == DRIVE_MUX2;
   assign drive_mode_out = mode_reg;
   assign bias_half_out = bias_reg;
   assign disp_enable_out = en_reg;
   assign out_bank_out = obank_reg;
   assign blink_rate_field = rate_reg;
   assign blink_alt_out = alt_reg;
   assign disp_bank_out = bank_capable && (obank_reg ^ (alt_reg && phase_reg));
   // Normal blink blanks; alternate blink in 1:3/1:4 has no bank so it blanks too
   assign disp_blank_out = !en_reg || (phase_reg && !(alt_reg && bank_capable));

   a_ack_only_slot: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sda_oe_out |-> in_ack_reg && st_reg != ST_IDLE && st_reg != ST_ADDR)
      else $error("data line driven outside acknowledge");
   a_ack_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sda_oe_out && scl_rise |=> sda_oe_out throughout (scl_s2_reg [*1]))
      else $error("acknowledge released during high phase");
   a_start_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      start_det |=> st_reg == ST_ADDR && bit_reg == 4'h0)
      else $error("start did not restart address");
   a_stop_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      stop_det && !start_det |=> st_reg == ST_IDLE && !sda_oe_out)
      else $error("stop did not end transfer");
   a_data_match: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      push |-> st_reg == ST_DATA && sub_reg == strap_reg[2:0])
      else $error("store without subaddress match");
   a_cmd_ack: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      st_reg == ST_CMD && scl_rise && bit_reg == 4'h7 && !in_ack_reg && !start_det
      && !stop_det |=> ack_reg)
      else $error("command byte not acknowledged");
   a_blink_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      rate_reg == RATE_OFF |=> !phase_reg)
      else $error("blink phase active while off");
   a_blink_period: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      rate_reg == RATE_1 && $past(rate_reg) == RATE_1 && blk_reg < 12'h17F
      |=> blk_reg == $past(blk_reg) + 12'h001)
      else $error("blink counter skipped");
   c_data_stored: cover property (@(posedge clk_sys_in) push);
   c_nack_addr: cover property (@(posedge clk_sys_in)
      st_reg == ST_ADDR ##1 st_reg == ST_IDLE);
   c_alt_swap: cover property (@(posedge clk_sys_in) $changed(disp_bank_out));
endmodule

// >>> lcb_master_model.sv
/*
 File: behavioural two-wire bus master that drives the receiver's serial pins.
 Assumes: this master is the only driver of the serial clock; the data line has a
 pull-up and the bench resolves it from both parties' pull-downs; the bench calls the tasks.
*/
`timescale 1ns/10ps
module lcb_master_model #(
   parameter int HALF = 10
) (
   // Clock
   input wire logic clk_sys_in,
   // Serial bus
   input wire logic sda_line_in,
   output logic scl_out,
   output logic sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   // Entered from idle or, as a repeated start, with the clock low after an acknowledge
   task automatic start_cond();
      sda_low_out = 1'b0;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      sda_low_out = 1'b1;
      tick(HALF);
      scl_out = 1'b0;
      tick(HALF);
   endtask

   task automatic stop_cond();
      sda_low_out = 1'b1;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      sda_low_out = 1'b0;
      tick(HALF);
   endtask

   // Data moves only while the clock is low; the line is checked at the end of each high phase
   task automatic write_byte(input logic [7:0] b, output logic ack, output logic meddle);
      meddle = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sda_low_out = ~b[i];
         tick(HALF);
         scl_out = 1'b1;
         tick(HALF);
         if (sda_line_in !== b[i]) meddle = 1'b1;
         scl_out = 1'b0;
         // Data moves a cycle after the clock has fallen, never with it
         tick(1);
      end
      // Ninth pulse: released line must read low early and late in the high phase
      sda_low_out = 1'b0;
      tick(HALF);
      scl_out = 1'b1;
      tick(1);
      ack = (sda_line_in === 1'b0);
      tick(HALF - 1);
      ack = ack & (sda_line_in === 1'b0);
      scl_out = 1'b0;
      tick(1);
   endtask
endmodule

// >>> lcb_receiver_tb_top.sv
/*
 File: self-checking bench for the serial receiver, blinker and display write queue.
 Assumes: the master model sits on the serial pins; the bench drains the queue itself.
*/
`timescale 1ns/10ps
module lcb_receiver_tb_top
   import lcb_pkg::*;
;
`define CHK(act, exp, msg) begin tests_run++; if ((act) !== (exp)) begin fail_count++; \
 $display("FAIL %0t %s", $time, msg); end end
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr_ready_in = 1'b0;
   logic addr_select_pin = 1'b0;
   logic hw_subaddr_pin0 = 1'b0;
   logic hw_subaddr_pin1 = 1'b0;
   logic hw_subaddr_pin2 = 1'b0;
   logic scl, sda_low, sda_line, sda_out, sda_oe_out, wr_valid_out, wr_bank_out;
   logic bias_half_out, disp_enable_out, out_bank_out, blink_alt_out, disp_blank_out;
   logic disp_bank_out, fifo_stall_out;
   logic [5:0] wr_ptr_out;
   logic [7:0] wr_data_out;
   logic [1:0] drive_mode_out, blink_rate_field;
   int fail_count = 0;
   int tests_run = 0;
   int n;
   int half_tbl[4] = '{4000, BLINK_DIV1 / 2, BLINK_DIV2 / 2, BLINK_DIV3 / 2};

   always #2.5 clk_sys_in = ~clk_sys_in;
   assign sda_line = (sda_low || (sda_oe_out && sda_out === 1'b0)) ? 1'b0 : 1'b1;

   lcb_master_model #(.HALF(10)) i_lcb_master_model (.clk_sys_in(clk_sys_in),
      .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(sda_low));

   lcb_receiver i_lcb_receiver (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .addr_select_pin(addr_select_pin), .hw_subaddr_pin0(hw_subaddr_pin0),
      .hw_subaddr_pin1(hw_subaddr_pin1), .hw_subaddr_pin2(hw_subaddr_pin2),
      .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_ptr_out(wr_ptr_out),
      .wr_data_out(wr_data_out), .wr_bank_out(wr_bank_out), .drive_mode_out(drive_mode_out),
      .bias_half_out(bias_half_out), .disp_enable_out(disp_enable_out),
      .out_bank_out(out_bank_out), .blink_rate_field(blink_rate_field),
      .blink_alt_out(blink_alt_out), .disp_blank_out(disp_blank_out),
      .disp_bank_out(disp_bank_out), .fifo_stall_out(fifo_stall_out));

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // The device acknowledges even a byte that a full queue drops
   task automatic wb(input logic [7:0] b, input logic exp);
      logic ack, med;
      i_lcb_master_model.write_byte(b, ack, med);
      `CHK(ack, exp, "acknowledge")
      `CHK(med, 1'b0, "data line disturbed")
   endtask

   task automatic cmd(input logic [7:0] c);
      i_lcb_master_model.start_cond();
      wb(8'h70, 1'b1);
      wb(c, 1'b1);
      i_lcb_master_model.stop_cond();
   endtask

   task automatic pop(input logic [5:0] p, input logic [7:0] d, input logic bk);
      int c;
      c = 0;
      while (wr_valid_out !== 1'b1 && c < 100) begin
         @(negedge clk_sys_in);
         c++;
      end
      `CHK(wr_ptr_out, p, "write pointer")
      `CHK(wr_data_out, d, "write data")
      `CHK(wr_bank_out, bk, "write bank")
      wr_ready_in = 1'b1;
      @(negedge clk_sys_in);
      wr_ready_in = 1'b0;
      // One idle edge so back-to-back pops never set ready twice in a step
      @(negedge clk_sys_in);
   endtask

   // Syncs to one toggle, then counts clocks to the next; 4000 means none seen
   task automatic measure(input logic bank, output int cnt);
      logic s;
      int c;
      c = 0;
      s = bank ? disp_bank_out : disp_blank_out;
      while ((bank ? disp_bank_out : disp_blank_out) === s && c < 4000) begin
         @(negedge clk_sys_in);
         c++;
      end
      s = bank ? disp_bank_out : disp_blank_out;
      cnt = 0;
      while ((bank ? disp_bank_out : disp_blank_out) === s && cnt < 4000) begin
         @(negedge clk_sys_in);
         cnt++;
      end
   endtask

   initial begin
      repeat (60000) @(negedge clk_sys_in);
      fail_count++;
      $display("FAIL %0t watchdog expired", $time);
      summarize();
   end

   initial begin
      repeat (4) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      `CHK(disp_enable_out, 1'b0, "enable after reset");
      `CHK(disp_blank_out, 1'b1, "blank after reset");
      `CHK(blink_rate_field, RATE_RST, "rate after reset");
      `CHK(wr_valid_out, 1'b0, "queue after reset");
      // Other select level, then a read request: both ignored
      i_lcb_master_model.start_cond();
      wb(8'h72, 1'b0);
      wb(8'hC9, 1'b0);
      i_lcb_master_model.stop_cond();
      i_lcb_master_model.start_cond();
      wb(8'h71, 1'b0);
      i_lcb_master_model.stop_cond();
      addr_select_pin = 1'b1;
      i_lcb_master_model.start_cond();
      wb(8'h72, 1'b1);
      i_lcb_master_model.stop_cond();
      addr_select_pin = 1'b0;
      // Static mode, both banks 1: five bytes fill the device, the sixth belongs to the next one
      i_lcb_master_model.start_cond();
      wb(8'h70, 1'b1);
      wb(8'hC9, 1'b1);
      wb(8'hE0, 1'b1);
      wb(8'hFB, 1'b1);
      wb(8'h00, 1'b1);
      for (int k = 0; k < 6; k++) wb(8'h10 + 8'(k), k < 5);
      i_lcb_master_model.start_cond();
      wb(8'h70, 1'b1);
      wb(8'hE0, 1'b1);
      wb(8'h03, 1'b1);
      wb(8'h5A, 1'b1);
      i_lcb_master_model.stop_cond();
      `CHK(drive_mode_out, DRIVE_STATIC, "drive mode");
      `CHK(disp_blank_out, 1'b0, "enabled display");
      `CHK(out_bank_out, 1'b1, "output bank");
      `CHK(disp_bank_out, 1'b1, "alternate rows shown");
      for (int k = 0; k < 5; k++) pop(6'(k * 8), 8'h10 + 8'(k), 1'b1);
      pop(6'h03, 8'h5A, 1'b1);
      `CHK(wr_valid_out, 1'b0, "no store on mismatch");
      for (int r = 0; r < 4; r++) begin
         cmd(8'h70 | 8'(r));
         measure(1'b0, n);
         `CHK(n, half_tbl[r], "blink half period");
      end
      `CHK(blink_rate_field, RATE_3, "rate field");
      cmd(8'h75);
      measure(1'b1, n);
      `CHK(n, BLINK_DIV1 / 2, "bank swap half period");
      `CHK(blink_alt_out, 1'b1, "alternate flag");
      `CHK(disp_blank_out, 1'b0, "no blanking in swap");
      cmd(8'h45);
      `CHK(disp_blank_out, 1'b1, "disabled display");
      `CHK(bias_half_out, 1'b1, "bias flag");
      // Queue fill with the consumer stalled, 1:4 mode, two runs of twenty bytes
      i_lcb_master_model.start_cond();
      wb(8'h70, 1'b1);
      wb(8'hC8, 1'b1);
      for (int t = 0; t < 2; t++) begin
         if (t == 1) begin
            i_lcb_master_model.start_cond();
            wb(8'h70, 1'b1);
         end
         wb(8'hE0, 1'b1);
         wb(8'h00, 1'b1);
         for (int k = 0; k < 20; k++) wb(8'(k + 20 * t), 1'b1);
      end
      i_lcb_master_model.stop_cond();
      `CHK(fifo_stall_out, 1'b1, "queue full");
      `CHK(drive_mode_out, DRIVE_MUX4, "drive mode 1:4");
      `CHK(disp_bank_out, 1'b0, "no bank swap in 1:4");
      for (int k = 0; k < 32; k++) pop(6'((k % 20) * 2), 8'(k), 1'b0);
      `CHK(wr_valid_out, 1'b0, "queue drained");
      `CHK(fifo_stall_out, 1'b0, "queue not full");
      summarize();
   end
endmodule
